/* hw/pin_ctrl_if.sv */
// Bundle between the register core and the direction resolver.
// Assumes both ends sit on the same clock; the resolver is purely combinational.
`timescale 1ns/10ps
`default_nettype none
interface pin_ctrl_if;
    logic [7:0] dir_bits;        // Software direction bits
    logic       spi_on;          // SPI enabled and routed here
    logic [3:0] spi_dir;         // SPI wanted directions, pins 7..4
    logic       iic_on;          // Two-wire bus enabled and routed here
    logic       can_on;          // CAN controller enabled
    logic       sci_on;          // Async serial interface enabled
    logic [7:0] pulse_on;        // Pulse channel enabled and routed here
    logic       pulse7_shutdown; // Channel 7 routed here as shutdown input
    logic [7:0] dir;             // Resolved direction, 1 = output
    logic [7:0] od;              // Resolved open-drain request

    modport resolver (
        input  dir_bits, spi_on, spi_dir, iic_on, can_on, sci_on, pulse_on, pulse7_shutdown,
        output dir, od
    );
    modport owner (
        output dir_bits, spi_on, spi_dir, iic_on, can_on, sci_on, pulse_on, pulse7_shutdown,
        input  dir, od
    );
endinterface
`default_nettype wire

/* hw/port_s_dir_input.sv */
// Port S direction control and raw pin level readback.
// Assumes a single-cycle strobe register port and enable levels from the
// peripherals that share the pins, all synchronous to sys_clk_i.
`timescale 1ns/10ps
`default_nettype none

//Contract
// - Level readback returns synchronised pin levels
// - Writes to level readback change nothing
// - Level readback has no reset value
// - Direction bit one output, zero input
// - Pin 7: SPI, two-wire, channel 3, bit
// - Pin 6: SPI, channel 2, bit
// - Pin 5: SPI, channel 1, bit
// - Pin 4: SPI, two-wire, channel 0, bit
// - CAN enabled forces pin 3 output
// - CAN enabled forces pin 2 input
// - Pin 1: serial out, channel 7 mode, bit
// - Pin 0: serial in, channel 6, bit
// - Reads settle two clocks after direction change
// - Data view: stored bit or pin level
// - Route select decides SPI, two-wire placement
module port_s_dir_input
    import port_s_pkg::*;
(
    input  wire logic                          sys_clk_i,
    input  wire logic                          resetn_i,
    input  wire logic [port_s_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [port_s_pkg::DATA_W-1:0] wr_data_i,
    input  wire logic                          wr_en_i,
    input  wire logic                          rd_en_i,
    output logic      [port_s_pkg::DATA_W-1:0] rd_data_o,
    input  wire logic [7:0]                    port_s_pins_i,
    input  wire logic [7:0]                    port_output_data_i,
    input  wire logic [7:0]                    peripheral_route_select_i,
    input  wire logic                          spi_en_i,
    input  wire logic [3:0]                    spi_dir_i,
    input  wire logic                          two_wire_bus_en_i,
    input  wire logic                          can_en_i,
    input  wire logic                          async_serial_iface_en_i,
    input  wire logic [7:0]                    pulse_en_i,
    input  wire logic [7:0]                    pulse_routed_i,
    input  wire logic                          pulse_channel_7_shutdown_i,
    output logic      [7:0]                    pin_dir_o,
    output logic      [7:0]                    pin_open_drain_o
);
    import port_s_pkg::*;

    pin_ctrl_if ctl ();

    logic [7:0] pin_direction_bits;
    logic [7:0] next_pin_direction_bits;
    logic [7:0] pin_level_readback;
    logic [7:0] data_view;
    logic [7:0] next_rd_data;
    logic [7:0] next_pin_dir;
    logic [7:0] next_pin_open_drain;

    port_s_sync u_sync (
        .sys_clk_i (sys_clk_i),
        .pins_i    (port_s_pins_i),
        .level_o   (pin_level_readback)
    );

    port_s_dir_resolve u_resolve (
        .ctl (ctl.resolver)
    );

    always_comb begin
        ctl.dir_bits        = pin_direction_bits;
        ctl.spi_on          = spi_en_i &&
            (peripheral_route_select_i[SPI_ROUTE_LSB +: 2] == SPI_ROUTE_HERE);
        ctl.spi_dir         = spi_dir_i;
        ctl.iic_on          = two_wire_bus_en_i && !peripheral_route_select_i[IIC_ROUTE_BIT];
        ctl.can_on          = can_en_i;
        ctl.sci_on          = async_serial_iface_en_i;
        ctl.pulse_on        = pulse_en_i & pulse_routed_i;
        ctl.pulse7_shutdown = pulse_routed_i[PULSE_ON_PIN1] && pulse_channel_7_shutdown_i;
    end

    assign data_view = (port_output_data_i & pin_direction_bits) |
                       (pin_level_readback & ~pin_direction_bits);

    // Next values for the direction register, read data and pin controls
    always_comb begin
        next_pin_direction_bits = pin_direction_bits;
        next_rd_data            = UNMAPPED_READ;
        next_pin_dir            = ctl.dir;
        next_pin_open_drain     = ctl.od;
        if (wr_en_i && addr_i == DIR_OFFS) begin
            next_pin_direction_bits = wr_data_i;
        end
        // Read data stands only in the cycle after the strobe
        if (rd_en_i) begin
            unique case (addr_i)
                PIN_LEVEL_OFFS: next_rd_data = pin_level_readback;
                DIR_OFFS:       next_rd_data = pin_direction_bits;
                DATA_VIEW_OFFS: next_rd_data = data_view;
                default:        next_rd_data = UNMAPPED_READ;
            endcase
        end
    end

    // Register stage; outputs come straight from flops to keep pad timing clean
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_direction_bits <= DIR_RESET;
            rd_data_o          <= RD_RESET;
            pin_dir_o          <= DIR_RESET;
            pin_open_drain_o   <= 8'h00;
        end else begin
            pin_direction_bits <= next_pin_direction_bits;
            rd_data_o          <= next_rd_data;
            pin_dir_o          <= next_pin_dir;
            pin_open_drain_o   <= next_pin_open_drain;
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    logic no_override;
    assign no_override = !ctl.spi_on && !ctl.iic_on && (ctl.pulse_on == 8'h00) &&
                         !can_en_i && !async_serial_iface_en_i && !ctl.pulse7_shutdown;

    level_readback_a: assert property (
        rd_en_i && addr_i == PIN_LEVEL_OFFS |=> rd_data_o == $past(pin_level_readback))
        else $error("level readback data wrong");

    readonly_write_a: assert property (
        wr_en_i && addr_i == PIN_LEVEL_OFFS |=> $stable(pin_direction_bits))
        else $error("write to level readback changed state");

    dir_write_a: assert property (
        wr_en_i && addr_i == DIR_OFFS ##1 no_override |=> pin_dir_o == $past(wr_data_i, 2))
        else $error("direction bits not applied to pins");

    spi_owns_a: assert property (
        ctl.spi_on |=> pin_dir_o[7:4] == $past(spi_dir_i) && pin_open_drain_o == 8'h00)
        else $error("spi did not own pins 7 to 4");

    two_wire_od_a: assert property (
        !ctl.spi_on && ctl.iic_on |=> pin_dir_o[7] && pin_dir_o[4] &&
        pin_open_drain_o[7] && pin_open_drain_o[4])
        else $error("two-wire bus pins not open-drain outputs");

    pulse_pin6_a: assert property (
        !ctl.spi_on && ctl.pulse_on[PULSE_ON_PIN6] |=> pin_dir_o[6])
        else $error("channel 2 did not force pin 6 output");

    pulse_pin5_a: assert property (
        !ctl.spi_on && ctl.pulse_on[PULSE_ON_PIN5] |=> pin_dir_o[5])
        else $error("channel 1 did not force pin 5 output");

    pulse_pin7_a: assert property (
        !ctl.spi_on && !ctl.iic_on && ctl.pulse_on[PULSE_ON_PIN7] |=>
        pin_dir_o[7] && !pin_open_drain_o[7])
        else $error("channel 3 did not force pin 7 output");

    shutdown_input_a: assert property (
        !async_serial_iface_en_i && ctl.pulse7_shutdown |=> !pin_dir_o[PIN_SCI_TX])
        else $error("shutdown use did not make pin 1 input");

    can_tx_a: assert property (
        can_en_i |=> pin_dir_o[PIN_CAN_TX])
        else $error("can transmit pin not output");

    can_rx_a: assert property (
        can_en_i |=> !pin_dir_o[PIN_CAN_RX])
        else $error("can receive pin not input");

    serial_pins_a: assert property (
        async_serial_iface_en_i |=> pin_dir_o[PIN_SCI_TX] && !pin_dir_o[PIN_SCI_RX])
        else $error("serial pins wrong direction");

    pin0_pulse_a: assert property (
        !async_serial_iface_en_i && ctl.pulse_on[PULSE_ON_PIN0] |=> pin_dir_o[PIN_SCI_RX])
        else $error("channel 6 did not force pin 0 output");

    sync_latency_a: assert property (
        pin_level_readback == $past(port_s_pins_i, 2))
        else $error("pin level latency not two clocks");

    data_view_a: assert property (
        rd_en_i && addr_i == DATA_VIEW_OFFS |=> rd_data_o == $past(data_view))
        else $error("data view read wrong");

    gpio_default_a: assert property (
        no_override |=> pin_dir_o == $past(pin_direction_bits) && pin_open_drain_o == 8'h00)
        else $error("direction bits not followed");

    cover_spi_c:    cover property (ctl.spi_on ##1 pin_dir_o[7:4] != 4'h0);
    cover_iic_c:    cover property (!ctl.spi_on && ctl.iic_on ##1 pin_open_drain_o[7]);
    cover_wr_rd_c:  cover property (wr_en_i && addr_i == DIR_OFFS ##1 rd_en_i);
    cover_shut_c:   cover property (ctl.pulse7_shutdown && !async_serial_iface_en_i);

endmodule // port_s_dir_input
`default_nettype wire

/* hw/port_s_dir_resolve.sv */
// Priority resolver for the port S pin directions.
// Assumes enables and routes already combined by the owner of the bundle.
`timescale 1ns/10ps
`default_nettype none
module port_s_dir_resolve
    import port_s_pkg::*;
(
    pin_ctrl_if.resolver ctl
);
    // Per-pin priority chains, highest owner first
    always_comb begin
        ctl.dir = ctl.dir_bits;
        ctl.od  = 8'h00;
        if (ctl.spi_on) begin
            ctl.dir[7] = ctl.spi_dir[3];
        end else if (ctl.iic_on) begin
            ctl.dir[PIN_IIC_SDA] = 1'b1;
            ctl.od[PIN_IIC_SDA]  = 1'b1;
        end else if (ctl.pulse_on[PULSE_ON_PIN7]) begin
            ctl.dir[7] = 1'b1;
        end
        if (ctl.spi_on) begin
            ctl.dir[6] = ctl.spi_dir[2];
        end else if (ctl.pulse_on[PULSE_ON_PIN6]) begin
            ctl.dir[6] = 1'b1;
        end
        if (ctl.spi_on) begin
            ctl.dir[5] = ctl.spi_dir[1];
        end else if (ctl.pulse_on[PULSE_ON_PIN5]) begin
            ctl.dir[5] = 1'b1;
        end
        if (ctl.spi_on) begin
            ctl.dir[PIN_SPI_LSB] = ctl.spi_dir[0];
        end else if (ctl.iic_on) begin
            ctl.dir[PIN_IIC_SCL] = 1'b1;
            ctl.od[PIN_IIC_SCL]  = 1'b1;
        end else if (ctl.pulse_on[PULSE_ON_PIN4]) begin
            ctl.dir[4] = 1'b1;
        end
        if (ctl.can_on) begin
            ctl.dir[PIN_CAN_TX] = 1'b1;
        end
        if (ctl.can_on) begin
            ctl.dir[PIN_CAN_RX] = 1'b0;
        end
        // pin 1 chain; shutdown use wins over channel output
        if (ctl.sci_on) begin
            ctl.dir[PIN_SCI_TX] = 1'b1;
        end else if (ctl.pulse7_shutdown) begin
            ctl.dir[PIN_SCI_TX] = 1'b0;
        end else if (ctl.pulse_on[PULSE_ON_PIN1]) begin
            ctl.dir[PIN_SCI_TX] = 1'b1;
        end
        if (ctl.sci_on) begin
            ctl.dir[PIN_SCI_RX] = 1'b0;
        end else if (ctl.pulse_on[PULSE_ON_PIN0]) begin
            ctl.dir[PIN_SCI_RX] = 1'b1;
        end
    end
endmodule // port_s_dir_resolve
`default_nettype wire

/* hw/port_s_pkg.sv */
// Constants for the port S direction and pin level readback block.
// Assumes a byte-wide register port with a 16-bit address and one system clock.
package port_s_pkg;

    // Register port geometry
    localparam int          ADDR_W         = 16;
    localparam int          DATA_W         = 8;
    localparam int          PIN_COUNT      = 8;

    // Register offsets
    localparam logic [15:0] PIN_LEVEL_OFFS = 16'h0249;
    localparam logic [15:0] DIR_OFFS       = 16'h024a;
    localparam logic [15:0] DATA_VIEW_OFFS = 16'h0248;

    // Reset values
    localparam logic [7:0]  DIR_RESET      = 8'h00;
    localparam logic [7:0]  RD_RESET       = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ  = 8'h00;

    // Route select fields: SPI location in bits 5:4, two-wire location in bit 1
    localparam int          SPI_ROUTE_LSB  = 4;
    localparam logic [1:0]  SPI_ROUTE_HERE = 2'b00;
    localparam int          IIC_ROUTE_BIT  = 1;

    // Pin positions with a shared function
    localparam int          PIN_SPI_LSB    = 4;
    localparam int          PIN_IIC_SCL    = 4;
    localparam int          PIN_IIC_SDA    = 7;
    localparam int          PIN_CAN_TX     = 3;
    localparam int          PIN_CAN_RX     = 2;
    localparam int          PIN_SCI_TX     = 1;
    localparam int          PIN_SCI_RX     = 0;

    // Pulse channel indices that land on this port
    localparam int          PULSE_ON_PIN7  = 3;
    localparam int          PULSE_ON_PIN6  = 2;
    localparam int          PULSE_ON_PIN5  = 1;
    localparam int          PULSE_ON_PIN4  = 0;
    localparam int          PULSE_ON_PIN1  = 7;
    localparam int          PULSE_ON_PIN0  = 6;

    // Input synchroniser depth, also the settle time after a direction change
    localparam int          SYNC_STAGES    = 2;

endpackage

/* hw/port_s_sync.sv */
// Two-stage synchroniser for the eight port S pin levels.
// Assumes pins may change at any time relative to sys_clk_i.
`timescale 1ns/10ps
`default_nettype none
module port_s_sync
    import port_s_pkg::*;
(
    input  wire logic                 sys_clk_i,
    input  wire logic [PIN_COUNT-1:0] pins_i,
    output logic      [PIN_COUNT-1:0] level_o
);
    logic [PIN_COUNT-1:0] stage1;
    logic [PIN_COUNT-1:0] stage2;

    // no reset value
    // No reset on purpose: the level simply follows the pins
    genvar g;
    for (g = 0; g < PIN_COUNT; g++) begin : g_bit
        always_ff @(posedge sys_clk_i) begin
            stage1[g] <= pins_i[g];
            stage2[g] <= stage1[g];
        end
    end

    assign level_o = stage2;
endmodule // port_s_sync
`default_nettype wire

/* verif/port_s_pin_world.sv */
// Pad model for the eight port S pins, seen from the board side.
// Assumes pin_dir_o and pin_open_drain_o of the block drive the pad buffers.
`timescale 1ns/10ps
`default_nettype none
module port_s_pin_world (
    input  wire logic [7:0] dir_i,
    input  wire logic [7:0] od_i,
    input  wire logic [7:0] out_data_i,
    input  wire logic [7:0] ext_i,
    output logic      [7:0] pins_o
);
    // pad level resolve
    // Open drain never drives a one, so the board level shows then
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pins_o[i] = (dir_i[i] && !(od_i[i] && out_data_i[i])) ? out_data_i[i] : ext_i[i];
        end
    end
endmodule // port_s_pin_world
`default_nettype wire

/* verif/tb_port_s_dir_input.sv */
// Self-checking bench for port_s_dir_input with a pad model.
// Assumes a 10 MHz system clock and the strobe register port of the package.
`timescale 1ns/10ps
`default_nettype none
module tb_port_s_dir_input;
    import port_s_pkg::*;
    logic        sys_clk = 1'b0;
    logic        resetn  = 1'b0;
    logic [15:0] addr    = 16'h0000;
    logic [7:0]  wr_data = 8'h00;
    logic        wr_en   = 1'b0;
    logic        rd_en   = 1'b0;
    logic [7:0]  rd_data, pins, dir, od, d;
    logic [7:0]  out_data = 8'h00, route = 8'h00, p_en = 8'h00, p_rt = 8'h00, ext = 8'h5a;
    logic [3:0]  spi_dir  = 4'h0;
    logic        spi_en = 1'b0, iic_en = 1'b0, can_en = 1'b0, sci_en = 1'b0, p_sd = 1'b0;
    logic [7:0]  exp_q[$];
    logic        rd_seen = 1'b0;
    logic [15:0] rv;
    int          fail_count = 0, checked = 0, cycles = 0;

    always #50 sys_clk = ~sys_clk;

    port_s_dir_input DUT (
        .sys_clk_i(sys_clk), .resetn_i(resetn), .addr_i(addr), .wr_data_i(wr_data),
        .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rd_data), .port_s_pins_i(pins),
        .port_output_data_i(out_data), .peripheral_route_select_i(route),
        .spi_en_i(spi_en), .spi_dir_i(spi_dir), .two_wire_bus_en_i(iic_en),
        .can_en_i(can_en), .async_serial_iface_en_i(sci_en), .pulse_en_i(p_en),
        .pulse_routed_i(p_rt), .pulse_channel_7_shutdown_i(p_sd),
        .pin_dir_o(dir), .pin_open_drain_o(od));

    port_s_pin_world pads (.dir_i(dir), .od_i(od), .out_data_i(out_data), .ext_i(ext),
        .pins_o(pins));

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checked++;
        if (seen !== want) begin
            fail_count++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic summarize();
        if (fail_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        addr <= a; wr_data <= v; wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask

    // Note the expected byte, the watcher compares it one cycle later
    task automatic rd(input logic [15:0] a, input logic [7:0] want);
        @(posedge sys_clk);
        addr <= a; rd_en <= 1'b1;
        exp_q.push_back(want);
        @(posedge sys_clk);
        rd_en <= 1'b0;
    endtask

    // Pad level the block should sample with no override, from the expected direction
    function automatic logic [7:0] lvl(input logic [7:0] dr);
        return (dr & out_data) | (~dr & ext);
    endfunction

    function automatic logic [15:0] resolve(input logic [7:0] b);
        logic       s, t;
        logic [7:0] p, r;
        s = spi_en && (route[5:4] == 2'b00);
        t = iic_en && !route[1];
        p = p_en & p_rt;
        r[7] = s ? spi_dir[3] : (t | p[3] | b[7]);
        r[6] = s ? spi_dir[2] : (p[2] | b[6]);
        r[5] = s ? spi_dir[1] : (p[1] | b[5]);
        r[4] = s ? spi_dir[0] : (t | p[0] | b[4]);
        r[3] = can_en | b[3];
        r[2] = !can_en & b[2];
        r[1] = sci_en | (p_rt[7] ? (!p_sd & (p_en[7] | b[1])) : b[1]);
        r[0] = !sci_en & (p[6] | b[0]);
        return {(!s && t) ? 8'h90 : 8'h00, r};
    endfunction

    // Read data stand only in the cycle after the strobe
    always @(negedge sys_clk) begin
        if (rd_seen && exp_q.size() > 0) check(rd_data, exp_q.pop_front());
        rd_seen = rd_en;
    end

    // Hang guard well above the expected run length
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            summarize();
        end
    end

    initial begin
        void'($urandom(73907));
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(DIR_OFFS, DIR_RESET);
        rd(PIN_LEVEL_OFFS, 8'h5a);
        rd(16'h0300, UNMAPPED_READ);
        wr(PIN_LEVEL_OFFS, 8'ha5);
        rd(PIN_LEVEL_OFFS, 8'h5a);
        rd(DIR_OFFS, DIR_RESET);
        d = 8'($urandom);
        out_data <= 8'($urandom);
        wr(DIR_OFFS, d);
        @(posedge sys_clk);
        #1 check(dir, d);
        // allow two clocks for the synchroniser
        repeat (2) @(posedge sys_clk);
        rd(PIN_LEVEL_OFFS, lvl(d));
        rd(DIR_OFFS, d);
        rd(DATA_VIEW_OFFS, (out_data & d) | (lvl(d) & ~d));
        for (int i = 0; i < 150; i++) begin
            d = 8'($urandom);
            wr(DIR_OFFS, d);
            {route, p_en, p_rt} <= 24'($urandom);
            {spi_en, spi_dir, iic_en, can_en, sci_en, p_sd} <= 9'($urandom);
            @(posedge sys_clk);
            #1 rv = resolve(d);
            check(dir, rv[7:0]);
            check(od, rv[15:8]);
        end
        repeat (2) @(posedge sys_clk);
        summarize();
    end
endmodule // tb_port_s_dir_input
`default_nettype wire
